// *** pkg/bdp_pkg.sv ***
/*
 bdp_pkg: offsets, reset values, field positions and timing counts for the
 diagnostic and power-management capability register group.
 assumes a byte-addressed configuration space, one access per cycle.
*/
`default_nettype none
package bdp_pkg;
   // configuration offsets
   localparam logic [7:0]  OFS_VENDOR_ID   = 8'h00;
   localparam logic [7:0]  OFS_DEVICE_ID   = 8'h02;
   localparam logic [7:0]  OFS_DIAG        = 8'h93;
   localparam logic [7:0]  OFS_CAP_ID      = 8'hA0;
   localparam logic [7:0]  OFS_NEXT_CAP    = 8'hA1;
   localparam logic [7:0]  OFS_PM_CAP      = 8'hA2;
   // fixed and reset values
   localparam logic [7:0]  DIAG_RESET      = 8'h60;
   localparam logic [7:0]  CAP_ID_VALUE    = 8'h01;
   localparam logic [7:0]  NEXT_CAP_VALUE  = 8'h00;
   localparam logic [15:0] PM_CAP_RESET    = 16'hFE12;
   localparam logic [7:0]  GLOBAL_MASK     = 8'h9E;
   localparam logic [7:0]  LOCAL_MASK      = 8'h21;
   // diagnostic, power capability and legacy field positions
   localparam int DIAG_ID_MASK_BIT   = 7;
   localparam int DIAG_FIXED_ONE_BIT = 6;
   localparam int DIAG_ROUTE_BIT     = 5;
   localparam int DIAG_TXN_DIS_BIT   = 4;
   localparam int DIAG_LAT_EXT_BIT   = 3;
   localparam int DIAG_CARD_TMR_BIT  = 2;
   localparam int DIAG_HOST_TMR_BIT  = 1;
   localparam int PM_WAKE_COLD_BIT   = 15;
   localparam int LEGACY_ROUTE_BIT   = 4;
   // latency limits and discard timeouts in clocks
   localparam logic [6:0]  LATENCY_SHORT   = 7'h10;
   localparam logic [6:0]  LATENCY_LONG    = 7'h40;
   localparam logic [15:0] DISCARD_SHORT   = 16'h0400;
   localparam logic [15:0] DISCARD_LONG    = 16'h8000;
   localparam int          NUM_FUNCS       = 2;
endpackage
`default_nettype wire

// *** hw/bdp_discard_timer.sv ***
/*
 bdp_discard_timer: delayed-transaction discard timer for one side.
 assumes run stays high while the transaction waits; expiry is one pulse.
*/
`default_nettype none
module bdp_discard_timer (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   // control
   input  wire logic        short_sel,
   input  wire logic        run,
   // status
   output logic             expired
);
   logic [15:0] cnt_r;
   logic [15:0] cnt_nxt;
   wire  [15:0] limit = short_sel ? bdp_pkg::DISCARD_SHORT : bdp_pkg::DISCARD_LONG;
   wire         hit   = run && (cnt_r == limit - 16'h0001);

   assign cnt_nxt = (!run || hit) ? 16'h0000 : cnt_r + 16'h0001;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_r   <= 16'h0000;
         expired <= 1'b0;
      end else begin
         cnt_r   <= cnt_nxt;
         expired <= hit;
      end
   end
endmodule
`default_nettype wire

// *** hw/bdp_regs.sv ***
/*
 bdp_regs: diagnostic register and power-management capability header of a
 two-function bridge, with the side effects the diagnostic bits steer.
 assumes a simple config port: one read or write per cycle, byte enables,
 dword-aligned address, function number; read data is registered.
*/
// Overview of operation
// RULE1: id mask bit set makes vendor and device id reads return all ones
// RULE2: diagnostic bit 6 is read-only, always one, ignores writes
// RULE3: route bit clear: status change goes to host when legacy 803 bit 4 set
// RULE4: route bit set: status change goes when legacy 805 bits 7-4 are zero
// RULE5: delayed transaction disable bit turns off delayed-transaction handling
// RULE6: latency extend bit raises target latency limit from 16 to 64 clocks
// RULE7: card-side timer select: 2^10 clocks when set, 2^15 when clear
// RULE8: host-side timer select: 2^10 clocks when set, 2^15 when clear
// RULE9: software keeps diagnostic bit 0 unchanged when writing
// RULE10: software should write only zeros to the diagnostic register
// RULE11: diagnostic resets to 60h and sits at offset 93h in both functions
// RULE12: diagnostic bits return to defaults only on the global reset pin
// RULE13: bits 7 and 4-1 are one shared copy, written through function 0 only
// RULE14: capability_identifier at A0h always reads 01h
// RULE15: next capability link at A1h always reads 00h
// RULE16: power capability word at A2h resets to FE12h in each function
// RULE17: both functions advertise support for D0, D1, D2 and D3
// RULE18: firmware clears capability bit 15 when no auxiliary power exists
// RULE19: writes to read-only bits have no effect
`default_nettype none
module bdp_regs (
   // clock and resets
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   input  wire logic        global_reset_pin_n,
   // config access
   input  wire logic        cfg_rd,
   input  wire logic        cfg_wr,
   input  wire logic        cfg_func,
   input  wire logic [7:0]  cfg_addr,
   input  wire logic [3:0]  cfg_be,
   input  wire logic [31:0] cfg_wdata,
   output logic [31:0]      cfg_rdata,
   // identity inputs
   input  wire logic [15:0] vendor_id,
   input  wire logic [15:0] device_id,
   // legacy socket status per function
   input  wire logic [1:0]  legacy_803_bit4,
   input  wire logic [7:0]  legacy_805_hi0,
   input  wire logic [7:0]  legacy_805_hi1,
   input  wire logic [1:0]  status_change,
   output logic [1:0]       status_change_irq,
   // bridge control
   input  wire logic        host_txn_wait,
   input  wire logic        card_txn_wait,
   output logic             delayed_txn_enable,
   output logic [6:0]       target_latency_limit,
   output logic             host_discard,
   output logic             card_discard
);
   // shared global bits, per-function local bits
   logic [7:0]  glob_r;
   logic [7:0]  loc_r [bdp_pkg::NUM_FUNCS];
   logic [bdp_pkg::NUM_FUNCS-1:0] pm_wake_r;
   logic [31:0] rdata_nxt;

   // storage passed in as arguments so the assign below follows every register change
   function automatic logic [7:0] diag_view(input logic [7:0] glob, input logic [7:0] loc);
      diag_view = (glob & bdp_pkg::GLOBAL_MASK) | (loc & bdp_pkg::LOCAL_MASK)
                  | (8'h01 << bdp_pkg::DIAG_FIXED_ONE_BIT); // RULE2
   endfunction

   function automatic logic route_ok(input logic sel, input logic b803, input logic [3:0] hi805);
      route_ok = sel ? (hi805 == 4'h0) : b803;
   endfunction

   wire [7:0] dword_base = {cfg_addr[7:2], 2'b00};
   wire       hit_id     = (dword_base == bdp_pkg::OFS_VENDOR_ID);
   wire       hit_diag   = (dword_base == {bdp_pkg::OFS_DIAG[7:2], 2'b00});
   wire       hit_cap    = (dword_base == bdp_pkg::OFS_CAP_ID);
   wire       id_masked  = glob_r[bdp_pkg::DIAG_ID_MASK_BIT];
   wire [7:0] diag_cur   = diag_view(glob_r, loc_r[cfg_func]);
   wire       wr_diag    = cfg_wr && hit_diag && cfg_be[3];
   wire [7:0] wbyte      = cfg_wdata[31:24];
   wire       wr_pm      = cfg_wr && hit_cap && cfg_be[3];

   assign rdata_nxt = !cfg_rd ? 32'h0000_0000 :
                      hit_id  ? (id_masked ? 32'hFFFF_FFFF : {device_id, vendor_id}) : // RULE1
                      hit_diag ? {diag_cur, 24'h00_0000} : // RULE11
                      hit_cap ? {pm_wake_r[cfg_func] ? bdp_pkg::PM_CAP_RESET
                                   : (bdp_pkg::PM_CAP_RESET & 16'h7FFF), // RULE16 RULE17
                                 bdp_pkg::NEXT_CAP_VALUE, bdp_pkg::CAP_ID_VALUE} : // RULE14 RULE15
                      32'h0000_0000;

   // diagnostic bits only see the global reset pin, not function resets
   always_ff @(posedge sys_clk or negedge global_reset_pin_n) begin
      if (!global_reset_pin_n) begin
         glob_r   <= bdp_pkg::DIAG_RESET; // RULE12
         loc_r[0] <= bdp_pkg::DIAG_RESET; // RULE11
         loc_r[1] <= bdp_pkg::DIAG_RESET;
      end else if (wr_diag) begin
         if (!cfg_func)
            glob_r <= wbyte & bdp_pkg::GLOBAL_MASK; // RULE13
         loc_r[cfg_func] <= wbyte & bdp_pkg::LOCAL_MASK; // RULE19
      end
   end

   // only bit 15 of the capability word is writable, everything else fixed
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pm_wake_r <= {bdp_pkg::NUM_FUNCS{bdp_pkg::PM_CAP_RESET[bdp_pkg::PM_WAKE_COLD_BIT]}};
         cfg_rdata <= 32'h0000_0000;
      end else begin
         if (wr_pm)
            pm_wake_r[cfg_func] <= cfg_wdata[16 + bdp_pkg::PM_WAKE_COLD_BIT]; // RULE18 RULE19
         cfg_rdata <= rdata_nxt;
      end
   end

   // status change routing per function
   assign status_change_irq[0] = status_change[0] && route_ok(loc_r[0][bdp_pkg::DIAG_ROUTE_BIT],
                                 legacy_803_bit4[0], legacy_805_hi0[7:4]); // RULE3 RULE4
   assign status_change_irq[1] = status_change[1] && route_ok(loc_r[1][bdp_pkg::DIAG_ROUTE_BIT],
                                 legacy_803_bit4[1], legacy_805_hi1[7:4]); // RULE3 RULE4

   assign delayed_txn_enable   = !glob_r[bdp_pkg::DIAG_TXN_DIS_BIT]; // RULE5
   assign target_latency_limit = glob_r[bdp_pkg::DIAG_LAT_EXT_BIT] ?
                                 bdp_pkg::LATENCY_LONG : bdp_pkg::LATENCY_SHORT; // RULE6

   // timers idle whenever delayed transactions are disabled
   bdp_discard_timer u_host_tmr (
      .sys_clk   (sys_clk),
      .resetn    (resetn),
      .short_sel (glob_r[bdp_pkg::DIAG_HOST_TMR_BIT]), // RULE8
      .run       (host_txn_wait && delayed_txn_enable),
      .expired   (host_discard)
   );

   bdp_discard_timer u_card_tmr (
      .sys_clk   (sys_clk),
      .resetn    (resetn),
      .short_sel (glob_r[bdp_pkg::DIAG_CARD_TMR_BIT]), // RULE7
      .run       (card_txn_wait && delayed_txn_enable),
      .expired   (card_discard)
   );
endmodule
`default_nettype wire

// *** verification/bdp_regs_props.sv ***
/* bdp_regs_chk: port assertions for bdp_regs.
 assumes a bind onto every bdp_regs. */
`default_nettype none
module bdp_regs_chk (
   input wire logic        sys_clk,
   input wire logic        resetn,
   input wire logic        cfg_rd,
   input wire logic [7:0]  cfg_addr,
   input wire logic [31:0] cfg_rdata,
   input wire logic [15:0] vendor_id,
   input wire logic [15:0] device_id,
   input wire logic [1:0]  status_change,
   input wire logic [1:0]  status_change_irq,
   input wire logic        delayed_txn_enable,
   input wire logic [6:0]  target_latency_limit,
   input wire logic        host_discard
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   sequence rd_at(logic [5:0] dw);
      cfg_rd && cfg_addr[7:2] == dw;
   endsequence
   rd_idle_a: assert property (!$past(cfg_rd) |-> cfg_rdata == 32'h0) else $error("rdata not idle");
   cap_hdr_a: assert property (rd_at(6'h28) |=> cfg_rdata[15:0] == 16'h0001) else $error("cap hdr");
   diag_one_a: assert property (rd_at(6'h24) |=> cfg_rdata[30]) else $error("diag bit6");
   id_view_a: assert property (rd_at(6'h00) |=> cfg_rdata == {$past(device_id), $past(vendor_id)}
      || cfg_rdata == 32'hFFFFFFFF) else $error("id view");
   unmapped_rd_a: assert property (rd_at(6'h10) |=> cfg_rdata == 32'h0) else $error("unmapped");
   txn_dis_a: assert property (rd_at(6'h24) |=> cfg_rdata[28] != $past(delayed_txn_enable))
      else $error("txn disable");
   lat_ext_a: assert property (rd_at(6'h24) |=> (cfg_rdata[27] ? 7'h40 : 7'h10) == $past(target_latency_limit))
      else $error("latency");
   irq_gate_a: assert property ((status_change_irq & ~status_change) == 2'h0) else $error("irq");
   discard_gap_a: assert property (host_discard |=> !host_discard [*8]) else $error("discard");
endmodule
bind bdp_regs bdp_regs_chk u_chk (.*);
`default_nettype wire

// *** verification/bdp_regs_test.sv ***
/* bdp_regs_test: directed bench for bdp_regs.
 assumes the bench alone drives every port. */
`default_nettype none
module bdp_regs_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] DM = 32'hFF000000;
   wire logic [15:0] vendor_id = 16'h5A5A; // arbitrary value
   wire logic [15:0] device_id = 16'hC3C3; // arbitrary value
   logic        sys_clk, resetn, global_reset_pin_n, cfg_rd, cfg_wr, cfg_func, host_txn_wait, card_txn_wait;
   logic        delayed_txn_enable, host_discard, card_discard;
   logic [7:0]  cfg_addr, legacy_805_hi0, legacy_805_hi1;
   logic [3:0]  cfg_be;
   logic [31:0] cfg_wdata, cfg_rdata;
   logic [1:0]  legacy_803_bit4, status_change, status_change_irq;
   logic [6:0]  target_latency_limit;
   int          fails, checks_done, n;
   bdp_regs DUT (.*);
   task automatic ck(string nm, logic [31:0] e, logic [31:0] a);
      checks_done++;
      if (a !== e) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", nm, e, a);
      end
   endtask
   task automatic wr(logic f, logic [7:0] a, logic [3:0] b, logic [31:0] d);
      {cfg_func, cfg_addr, cfg_be, cfg_wdata, cfg_wr} = {f, a, b, d, 1'b1};
      @(posedge sys_clk) #5 cfg_wr = 0;
      @(posedge sys_clk) #5;
   endtask
   task automatic rd(logic f, logic [7:0] a, logic [31:0] m, logic [31:0] e, string nm);
      {cfg_func, cfg_addr, cfg_rd} = {f, a, 1'b1};
      @(posedge sys_clk) #5 cfg_rd = 0;
      ck(nm, e, cfg_rdata & m);
      @(posedge sys_clk) #5;
   endtask
   task automatic finish_test;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic t_reset;
      for (int f = 0; f < 2; f++) begin
         rd(f[0], 8'h93, DM, 32'h60000000, "diag");
         rd(f[0], 8'hA0, '1, 32'hFE120001, "cap");
         rd(f[0], 8'h00, '1, {device_id, vendor_id}, "id");
      end
      rd(0, 8'h40, '1, 32'h0, "unmapped");
      ck("txn enable", 32'h1, delayed_txn_enable);
      ck("latency", 32'h10, target_latency_limit);
   endtask
   task automatic t_diag;
      wr(1, 8'h90, 4'h8, 32'hBE000000);
      rd(0, 8'h93, DM, 32'h60000000, "diag f1 write");
      wr(0, 8'h90, 4'h8, 32'h9E000000);
      rd(0, 8'h93, DM, 32'hDE000000, "diag f0");
      rd(1, 8'h93, DM, 32'hFE000000, "diag f1");
      rd(1, 8'h00, '1, 32'hFFFFFFFF, "masked id");
      ck("txn enable", 32'h0, delayed_txn_enable);
      ck("latency", 32'h40, target_latency_limit);
   endtask
   task automatic t_irq;
      {status_change, legacy_803_bit4, legacy_805_hi0, legacy_805_hi1} = {2'h3, 2'h0, 8'hF0, 8'h00};
      @(posedge sys_clk) #5 ck("irq", 32'h2, status_change_irq);
      // function 1 routes on 805, so its 803 bit set here must be ignored
      {legacy_803_bit4, legacy_805_hi1} = {2'h3, 8'h10};
      @(posedge sys_clk) #5 ck("irq", 32'h1, status_change_irq);
      status_change = 2'h0;
   endtask
   task automatic t_timer;
      // delayed transactions still disabled here: no timer may fire
      {host_txn_wait, card_txn_wait} = 2'h3;
      n = 0;
      repeat (1100) @(posedge sys_clk) #5 n += host_discard + card_discard;
      ck("discard while disabled", 32'h0, n);
      {host_txn_wait, card_txn_wait} = 2'h0;
      wr(0, 8'h90, 4'h8, 32'h0C000000);
      ck("txn enable", 32'h1, delayed_txn_enable);
      // card side short, host side long
      {host_txn_wait, card_txn_wait} = 2'h3;
      n = 0;
      while (!card_discard && n < 1100) @(posedge sys_clk) #5 n++;
      ck("card discard time", 32'h400, n);
      ck("host discard early", 32'h0, host_discard);
      while (!host_discard && n < 33000) @(posedge sys_clk) #5 n++;
      ck("host discard time", 32'h8000, n);
      {host_txn_wait, card_txn_wait} = 2'h0;
      if (n >= 33000) finish_test();
   endtask
   task automatic t_pm;
      wr(0, 8'hA0, 4'hF, 32'h0);
      rd(0, 8'hA0, '1, 32'h7E120001, "pm f0");
      rd(1, 8'hA0, '1, 32'hFE120001, "pm f1");
   endtask
   task automatic t_resets;
      resetn = 0;
      @(posedge sys_clk) #5 resetn = 1;
      rd(0, 8'h93, DM, 32'h4C000000, "diag kept");
      rd(0, 8'hA0, '1, 32'hFE120001, "pm reset");
      global_reset_pin_n = 0;
      @(posedge sys_clk) #5 global_reset_pin_n = 1;
      rd(1, 8'h00, '1, {device_id, vendor_id}, "id");
      rd(1, 8'h93, DM, 32'h60000000, "diag cleared");
      wr(0, 8'h90, 4'h8, 32'h00000000);
      rd(0, 8'h93, DM, 32'h40000000, "diag zeros");
   endtask
   initial begin
      sys_clk = 0;
      forever #25 sys_clk = ~sys_clk;
   end
   initial begin
      {resetn, global_reset_pin_n, cfg_rd, cfg_wr, cfg_func, cfg_addr, cfg_be, cfg_wdata} = '0;
      {legacy_803_bit4, legacy_805_hi0, legacy_805_hi1, status_change, host_txn_wait, card_txn_wait} = '0;
      fails = 0;
      checks_done = 0;
      repeat (20) @(posedge sys_clk);
      #5 {resetn, global_reset_pin_n} = 2'h3;
      t_reset();
      t_diag();
      t_irq();
      t_timer();
      t_pm();
      t_resets();
      finish_test();
   end
endmodule
`default_nettype wire
